/* File: include/pmb_pkg.sv */
// Shared constants, command codes and types for the power-bus command decoder
package pmb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_PAGE        = 8'h00;
    localparam logic [7:0] CMD_OPERATION   = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
    localparam logic [7:0] CMD_CLR_FAULTS  = 8'h03;
    localparam logic [7:0] CMD_WR_PROTECT  = 8'h10;
    localparam logic [7:0] CMD_STORE_DEF   = 8'h11;
    localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
    localparam logic [7:0] CMD_STORE_USER  = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USR = 8'h16;
    localparam logic [7:0] CMD_VOUT_MODE   = 8'h20;
    localparam logic [7:0] CMD_VOUT_CMD    = 8'h21;
    localparam logic [7:0] CMD_VFAN1       = 8'h3a;
    localparam logic [7:0] CMD_OT_FAULT    = 8'h4f;
    localparam logic [7:0] CMD_OT_WARN     = 8'h51;
    localparam logic [7:0] CMD_TON_DELAY   = 8'h60;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_READ_VIN    = 8'h88;
    localparam logic [7:0] CMD_READ_IIN    = 8'h89;
    localparam logic [7:0] CMD_READ_VOUT   = 8'h8b;
    localparam logic [7:0] CMD_READ_FAN2   = 8'h91;
    localparam logic [7:0] CMD_REVISION    = 8'h98;

    ////////////////////////////////////////////////////////////////////////////
    // Module index and fault bits
    localparam logic [7:0] PAGE_MAX        = 8'h07;
    localparam logic [2:0] PAGE_RST        = 3'h0;
    localparam logic [7:0] FAULT_RST       = 8'h00;
    localparam int         FAULT_CMD_ERR   = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Host register map (byte addresses) and fields
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_WDATA    = 8'h04;
    localparam logic [7:0] REG_RDATA    = 8'h08;
    localparam logic [7:0] REG_STAT     = 8'h0c;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam int         CTRL_GO      = 0;
    localparam int         CTRL_WRITE   = 1;
    localparam int         CTRL_CNT_LO  = 4;
    localparam int         CTRL_CODE_LO = 8;
    localparam int         STAT_BUSY    = 0;
    localparam int         STAT_ERR     = 1;
    localparam int         INT_DONE     = 0;
    localparam int         INT_ERR      = 1;
    localparam logic [1:0] INT_RST      = 2'h0;

    typedef enum logic [2:0] {
        PMB_K_NONE,
        PMB_K_SEND,
        PMB_K_WR_BYTE,
        PMB_K_RW_BYTE,
        PMB_K_RD_BYTE,
        PMB_K_RW_WORD,
        PMB_K_RD_WORD
    } pmb_kind_t;

    // Data bytes a command carries
    function automatic logic [1:0] pmb_bytes(input pmb_kind_t k);
        case (k)
            PMB_K_WR_BYTE, PMB_K_RW_BYTE, PMB_K_RD_BYTE: pmb_bytes = 2'd1;
            PMB_K_RW_WORD, PMB_K_RD_WORD:                pmb_bytes = 2'd2;
            default:                                      pmb_bytes = 2'd0;
        endcase
    endfunction

    // Direction and byte count must match the command's transaction type
    function automatic logic pmb_legal(input pmb_kind_t k, input logic wr,
                                       input logic [1:0] cnt);
        logic dir_ok;
        dir_ok = 1'b0;
        case (k)
            PMB_K_SEND, PMB_K_WR_BYTE:    dir_ok = wr;
            PMB_K_RD_BYTE, PMB_K_RD_WORD: dir_ok = !wr;
            PMB_K_RW_BYTE, PMB_K_RW_WORD: dir_ok = 1'b1;
            default:                      dir_ok = 1'b0;
        endcase
        pmb_legal = dir_ok && (cnt == pmb_bytes(k));
    endfunction

endpackage

/* File: include/pmb_link_if.sv */
// Link between the host end and the device end of the command path
`timescale 1ns/100ps
`default_nettype none
interface pmb_link_if;
    logic        req_valid;
    logic        req_write;
    logic [7:0]  req_code;
    logic [1:0]  req_count;
    logic [15:0] req_data;
    logic        resp_valid;
    logic        resp_err;
    logic [15:0] resp_data;

    modport host (
        output req_valid, req_write, req_code, req_count, req_data,
        input  resp_valid, resp_err, resp_data
    );
    modport dev (
        input  req_valid, req_write, req_code, req_count, req_data,
        output resp_valid, resp_err, resp_data
    );
endinterface
`default_nettype wire

/* File: verilog/pmb_cmd_table.sv */
// Command code to transaction type lookup
`timescale 1ns/100ps
`default_nettype none
module pmb_cmd_table
    import pmb_pkg::*;
(
    input  wire logic [7:0]  code_i,
    output pmb_pkg::pmb_kind_t kind_o
);
    import pmb_pkg::*;

    always_comb begin
        case (code_i)
            CMD_PAGE, CMD_OPERATION, CMD_ON_OFF_CFG,
            CMD_WR_PROTECT, CMD_VOUT_MODE:              kind_o = PMB_K_RW_BYTE;
            CMD_CLR_FAULTS, CMD_STORE_DEF,
            CMD_STORE_USER:                             kind_o = PMB_K_SEND;
            CMD_RESTORE_DEF, CMD_RESTORE_USR:           kind_o = PMB_K_WR_BYTE;
            CMD_VOUT_CMD, CMD_VFAN1, CMD_OT_FAULT,
            CMD_OT_WARN, CMD_TON_DELAY:                 kind_o = PMB_K_RW_WORD;
            CMD_STATUS_BYTE, CMD_REVISION:              kind_o = PMB_K_RD_BYTE;
            CMD_READ_VIN, CMD_READ_IIN, CMD_READ_VOUT,
            8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h90,
            CMD_READ_FAN2:                              kind_o = PMB_K_RD_WORD;
            default:                                    kind_o = PMB_K_NONE;
        endcase
    end
endmodule // pmb_cmd_table
`default_nettype wire

/* File: verilog/pmb_dev_end.sv */
// Device end: decodes commands, holds the module index and the latched faults
//
// Functional notes
// - Module index selects one of eight outputs
// - Module index holds only zero to seven
// - Module index resets to zero
// - Code 00h reads or writes module index
// - Codes 01h 02h 10h 20h: byte read/write
// - Code 03h: send byte, no data
// - Code 11h: send byte, store default set
// - Code 15h: send byte, store user set
// - Codes 12h 16h: one-byte write only
// - Codes 21h 3Ah 4Fh 51h 60h: word read/write
// - Code 78h: read-only byte
// - Telemetry codes: read-only word reads
// - Code 98h: read-only byte
// - Latched faults stay until fault clear
`timescale 1ns/100ps
`default_nettype none
module pmb_dev_end
    import pmb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    pmb_link_if.dev          link,
    // User side
    input  wire logic [15:0] rd_data_i,
    input  wire logic [7:0]  case_fault_set_i,
    input  wire logic [7:0]  comm_err_set_i,
    output logic [2:0]       page_o,
    output logic [7:0]       cmd_code_o,
    output logic             wr_stb_o,
    output logic [15:0]      wr_data_o,
    output logic             rd_stb_o,
    output logic             clear_faults_o,
    output logic             store_default_o,
    output logic             store_user_o,
    output logic             restore_default_o,
    output logic             restore_user_o,
    output logic             cmd_err_o,
    output logic [7:0]       case_fault_o,
    output logic [7:0]       comm_err_o
);
    import pmb_pkg::*;

    typedef enum logic [0:0] {
        PMB_S_IDLE,
        PMB_S_EXEC
    } pmb_dev_state_t;

    pmb_dev_state_t state_q;
    logic           write_q;
    logic [1:0]     count_q;
    pmb_kind_t      kind;
    logic           legal;
    logic           page_bad;
    logic           accept;
    logic           do_wr;
    logic           do_rd;
    logic           do_send;
    logic           fail;
    logic [7:0]     err_vec;
    logic [2:0]     page_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    pmb_cmd_table u_table (
        .code_i (cmd_code_o),
        .kind_o (kind)
    );

    always_comb begin
        legal    = pmb_legal(kind, write_q, count_q);
        // An out-of-range index is refused rather than truncated
        page_bad = (cmd_code_o == CMD_PAGE) && write_q
                   && (wr_data_o > {8'h00, PAGE_MAX});
        accept   = (state_q == PMB_S_EXEC) && legal && !page_bad;
        fail     = (state_q == PMB_S_EXEC) && !accept;
        do_send  = accept && (kind == PMB_K_SEND);
        do_wr    = accept && write_q && (kind != PMB_K_SEND);
        do_rd    = accept && !write_q;
        err_vec  = 8'h00;
        err_vec[FAULT_CMD_ERR] = fail;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing: a request is taken only when idle, answered the next cycle

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= PMB_S_IDLE;
        end else if (ce_i) begin
            case (state_q)
                PMB_S_IDLE: begin
                    if (link.req_valid) begin
                        state_q <= PMB_S_EXEC;
                    end
                end
                PMB_S_EXEC: begin
                    state_q <= PMB_S_IDLE;
                end
                default: begin
                    state_q <= PMB_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_code_o <= 8'h00;
            write_q    <= 1'b0;
            count_q    <= 2'h0;
            wr_data_o  <= 16'h0000;
        end else if (ce_i && state_q == PMB_S_IDLE && link.req_valid) begin
            cmd_code_o <= link.req_code;
            write_q    <= link.req_write;
            count_q    <= link.req_count;
            wr_data_o  <= link.req_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Module index

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            page_q <= PAGE_RST;
        end else if (ce_i && do_wr && cmd_code_o == CMD_PAGE) begin
            page_q <= wr_data_o[2:0];
        end
    end

    assign page_o = page_q;

    ////////////////////////////////////////////////////////////////////////////
    // Strobes toward the user logic, one cycle each

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_stb_o          <= 1'b0;
            rd_stb_o          <= 1'b0;
            clear_faults_o    <= 1'b0;
            store_default_o   <= 1'b0;
            store_user_o      <= 1'b0;
            restore_default_o <= 1'b0;
            restore_user_o    <= 1'b0;
            cmd_err_o         <= 1'b0;
        end else if (ce_i) begin
            // Module index writes stay internal and raise no user strobe
            wr_stb_o          <= do_wr && cmd_code_o != CMD_PAGE;
            rd_stb_o          <= do_rd;
            clear_faults_o    <= do_send && cmd_code_o == CMD_CLR_FAULTS;
            store_default_o   <= do_send && cmd_code_o == CMD_STORE_DEF;
            store_user_o      <= do_send && cmd_code_o == CMD_STORE_USER;
            restore_default_o <= do_wr && cmd_code_o == CMD_RESTORE_DEF;
            restore_user_o    <= do_wr && cmd_code_o == CMD_RESTORE_USR;
            cmd_err_o         <= fail;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched faults: a new event in the clearing cycle survives the clear

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            case_fault_o <= FAULT_RST;
            comm_err_o   <= FAULT_RST;
        end else if (ce_i) begin
            if (do_send && cmd_code_o == CMD_CLR_FAULTS) begin
                case_fault_o <= case_fault_set_i | err_vec;
                comm_err_o   <= comm_err_set_i;
            end else begin
                case_fault_o <= case_fault_o | case_fault_set_i | err_vec;
                comm_err_o   <= comm_err_o | comm_err_set_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link.resp_valid <= 1'b0;
            link.resp_err   <= 1'b0;
            link.resp_data  <= 16'h0000;
        end else if (ce_i) begin
            link.resp_valid <= state_q == PMB_S_EXEC;
            link.resp_err   <= fail;
            if (do_rd && cmd_code_o == CMD_PAGE) begin
                link.resp_data <= {13'h0000, page_q};
            end else if (do_rd && pmb_bytes(kind) == 2'd1) begin
                link.resp_data <= {8'h00, rd_data_i[7:0]};
            end else if (do_rd) begin
                link.resp_data <= rd_data_i;
            end else begin
                link.resp_data <= 16'h0000;
            end
        end
    end

endmodule // pmb_dev_end
`default_nettype wire

/* File: verilog/pmb_host_end.sv */
// Host end: register port for software, issues one command at a time
`timescale 1ns/100ps
`default_nettype none
module pmb_host_end
    import pmb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    pmb_link_if.host         link,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic             irq_o
);
    import pmb_pkg::*;

    typedef enum logic [1:0] {
        PMB_H_IDLE,
        PMB_H_SEND,
        PMB_H_WAIT
    } pmb_host_state_t;

    pmb_host_state_t state_q;
    logic [7:0]      code_q;
    logic            write_q;
    logic [1:0]      count_q;
    logic [15:0]     wdata_q;
    logic [15:0]     rdata_q;
    logic            err_q;
    logic [1:0]      int_stat_q;
    logic [1:0]      int_mask_q;
    logic            go;
    logic            go_bad;
    logic [1:0]      ev;

    always_comb begin
        go     = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_GO] && state_q == PMB_H_IDLE;
        // Never send an index the device cannot hold
        go_bad = go && wdata_i[CTRL_CODE_LO +: 8] == CMD_PAGE && wdata_i[CTRL_WRITE]
                 && wdata_q > {8'h00, PAGE_MAX};
        ev     = 2'h0;
        ev[INT_DONE] = (state_q == PMB_H_WAIT && link.resp_valid) || go_bad;
        ev[INT_ERR]  = (state_q == PMB_H_WAIT && link.resp_valid && link.resp_err)
                       || go_bad;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction sequencing

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= PMB_H_IDLE;
        end else if (ce_i) begin
            case (state_q)
                PMB_H_IDLE: begin
                    if (go && !go_bad) begin
                        state_q <= PMB_H_SEND;
                    end
                end
                PMB_H_SEND: begin
                    state_q <= PMB_H_WAIT;
                end
                PMB_H_WAIT: begin
                    if (link.resp_valid) begin
                        state_q <= PMB_H_IDLE;
                    end
                end
                default: begin
                    state_q <= PMB_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            code_q  <= 8'h00;
            write_q <= 1'b0;
            count_q <= 2'h0;
        end else if (ce_i && go) begin
            code_q  <= wdata_i[CTRL_CODE_LO +: 8];
            write_q <= wdata_i[CTRL_WRITE];
            count_q <= wdata_i[CTRL_CNT_LO +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wdata_q <= 16'h0000;
        end else if (ce_i && wr_i && addr_i == REG_WDATA && state_q == PMB_H_IDLE) begin
            wdata_q <= wdata_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link.req_valid <= 1'b0;
            link.req_write <= 1'b0;
            link.req_code  <= 8'h00;
            link.req_count <= 2'h0;
            link.req_data  <= 16'h0000;
        end else if (ce_i) begin
            link.req_valid <= state_q == PMB_H_IDLE && go && !go_bad;
            link.req_write <= wdata_i[CTRL_WRITE];
            link.req_code  <= wdata_i[CTRL_CODE_LO +: 8];
            link.req_count <= wdata_i[CTRL_CNT_LO +: 2];
            link.req_data  <= wdata_q;
            if (!go) begin
                link.req_write <= link.req_write;
                link.req_code  <= link.req_code;
                link.req_count <= link.req_count;
                link.req_data  <= link.req_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 16'h0000;
            err_q   <= 1'b0;
        end else if (ce_i && ((state_q == PMB_H_WAIT && link.resp_valid) || go_bad)) begin
            rdata_q <= go_bad ? 16'h0000 : link.resp_data;
            err_q   <= go_bad | link.resp_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a write-one clear

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_stat_q <= INT_RST;
            int_mask_q <= INT_RST;
            irq_o      <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && addr_i == REG_INT_STAT) begin
                int_stat_q <= (int_stat_q & ~wdata_i[1:0]) | ev;
            end else begin
                int_stat_q <= int_stat_q | ev;
            end
            if (wr_i && addr_i == REG_INT_MASK) begin
                int_mask_q <= wdata_i[1:0];
            end
            irq_o <= |(int_stat_q & int_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe, unmapped reads give zero

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_o <= 32'h0000_0000;
            if (rd_i && addr_i == REG_CTRL) begin
                rdata_o <= {16'h0000, code_q, 2'h0, count_q, 2'h0, write_q, 1'b0};
            end else if (rd_i && addr_i == REG_WDATA) begin
                rdata_o <= {16'h0000, wdata_q};
            end else if (rd_i && addr_i == REG_RDATA) begin
                rdata_o <= {16'h0000, rdata_q};
            end else if (rd_i && addr_i == REG_STAT) begin
                rdata_o <= {30'h0000_0000, err_q, state_q != PMB_H_IDLE};
            end else if (rd_i && addr_i == REG_INT_STAT) begin
                rdata_o <= {30'h0000_0000, int_stat_q};
            end else if (rd_i && addr_i == REG_INT_MASK) begin
                rdata_o <= {30'h0000_0000, int_mask_q};
            end
        end
    end

endmodule // pmb_host_end
`default_nettype wire

/* File: tb/pmb_link_chk.sv */
// Checker on the link that joins the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module pmb_link_chk (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_code,
    input  wire logic [1:0]  req_count,
    input  wire logic [15:0] req_data,
    input  wire logic        resp_valid,
    input  wire logic        resp_err,
    input  wire logic [15:0] resp_data
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic is_send;
    logic is_byte;
    logic is_word;
    logic is_ro;
    assign is_send = req_code inside {8'h03, 8'h11, 8'h15};
    assign is_byte = req_code inside {8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h78, 8'h98};
    assign is_word = req_code inside {8'h21, 8'h3a, 8'h4f, 8'h51, 8'h60};
    assign is_ro   = req_code inside {8'h78, [8'h88:8'h89], [8'h8b:8'h91], 8'h98};

    ////////////////////////////////////////////////////////////////////////////
    // Every answer lands exactly two edges after its request
    sequence s_ok;
        ##2 resp_valid && !resp_err;
    endsequence
    sequence s_bad;
        ##2 resp_valid && resp_err;
    endsequence

    a_resp_two_late: assert property (req_valid |-> ##2 resp_valid)
        else $error("answer not two cycles after request");
    a_resp_has_req: assert property (resp_valid |-> $past(req_valid, 2))
        else $error("answer without request");
    a_req_gap_kept: assert property (req_valid |=> !req_valid [*2])
        else $error("requests closer than three cycles");
    a_err_data_zero: assert property (resp_valid && resp_err |-> resp_data == 16'h0000)
        else $error("refused answer carries data");
    a_byte_rd_ok: assert property (
        req_valid && !req_write && req_count == 2'd1 && is_byte
        |-> s_ok ##0 resp_data[15:8] == 8'h00)
        else $error("byte read refused or upper byte set");
    a_page_in_range: assert property (
        req_valid && !req_write && req_code == 8'h00
        |-> ##2 resp_data[15:3] == 13'h0000)
        else $error("module index out of range");
    a_send_ok: assert property (
        req_valid && req_write && req_count == 2'd0 && is_send |-> s_ok)
        else $error("send byte refused");
    a_send_count: assert property (
        req_valid && req_count != 2'd0 && is_send |-> s_bad)
        else $error("send byte with data accepted");
    a_restore_rd: assert property (
        req_valid && !req_write && req_code inside {8'h12, 8'h16} |-> s_bad)
        else $error("restore read accepted");
    a_word_ok: assert property (req_valid && req_count == 2'd2 && is_word |-> s_ok)
        else $error("word command refused");
    a_ro_write: assert property (req_valid && req_write && is_ro |-> s_bad)
        else $error("write to read-only code accepted");
    a_tele_rd_ok: assert property (
        req_valid && !req_write && req_count == 2'd2 && is_ro && !is_byte |-> s_ok)
        else $error("telemetry read refused");
    a_unknown_bad: assert property (
        req_valid && !(is_send || is_byte || is_word || is_ro || req_code inside {8'h12, 8'h16})
        |-> s_bad)
        else $error("unsupported code accepted");
endmodule // pmb_link_chk
`default_nettype wire

/* File: tb/test_pmbus_command_decoder.sv */
// Bench for the command path: both ends joined by the link
`timescale 1ns/100ps
`default_nettype none
module test_pmbus_command_decoder;
    import pmb_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_q = 1'b0;
    logic [15:0] rd_data = 16'h0;
    logic [7:0]  cf_set = 8'h00;
    logic [7:0]  ce_set = 8'h00;
    logic [31:0] rdata;
    logic        irq;
    logic [2:0]  page;
    logic [7:0]  cf;
    logic [7:0]  ce;
    logic [15:0] wdat;
    wire  [7:0]  pl;
    logic [15:0] wd;
    logic [15:0] rnd;
    logic [19:0] t;
    logic        mk = 1'b1;
    logic        run = 1'b1;
    int          err_total = 0;
    int          num_checks = 0;
    int          seed = 32'h7193;
    int          n_pulse[8] = '{default: 0};
    logic [31:0] exp_q[$];
    logic [19:0] tbl[30] = '{20'h01110, 20'h02010, 20'h10110, 20'h20010, 20'h03111, 20'h11100,
        20'h15100, 20'h12110, 20'h16110, 20'h12011, 20'h21120, 20'h3a020, 20'h4f111, 20'h51020,
        20'h60120, 20'h78010, 20'h78111, 20'h88020, 20'h89020, 20'h8b020, 20'h8c020, 20'h8d020,
        20'h8e020, 20'h8f020, 20'h90020, 20'h91020, 20'h98010, 20'h98111, 20'h8a021, 20'h04101};

    pmb_link_if link ();
    pmb_host_end u_pmb_host_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(run), .link(link),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
    pmb_dev_end u_pmb_dev_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(run), .link(link),
        .rd_data_i(rd_data), .case_fault_set_i(cf_set), .comm_err_set_i(ce_set), .page_o(page),
        .cmd_code_o(), .wr_stb_o(pl[6]), .wr_data_o(wdat), .rd_stb_o(pl[7]),
        .clear_faults_o(pl[0]), .store_default_o(pl[1]), .store_user_o(pl[2]),
        .restore_default_o(pl[3]), .restore_user_o(pl[4]), .cmd_err_o(pl[5]), .case_fault_o(cf),
        .comm_err_o(ce));
    pmb_link_chk u_pmb_link_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_valid(link.req_valid), .req_write(link.req_write), .req_code(link.req_code),
        .req_count(link.req_count), .req_data(link.req_data), .resp_valid(link.resp_valid),
        .resp_err(link.resp_err), .resp_data(link.resp_data));

    always #4 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic br(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd <= 1'b0;
    endtask

    // One command end to end; refused ones must report done and error both
    task automatic cmd(input logic [7:0] c, input logic w, input logic [1:0] n,
                       input logic [15:0] d, input logic e, input logic [15:0] r);
        bw(REG_WDATA, {16'h0, d});
        bw(REG_CTRL, {16'h0, c, 2'b00, n, 2'b00, w, 1'b1});
        chk(irq, 1'b0);
        repeat (6) @(posedge clk_i);
        chk(irq, mk);
        br(REG_STAT, {30'h0, e, 1'b0});
        br(REG_INT_STAT, {30'h0, e, 1'b1});
        br(REG_RDATA, e ? 32'h0 : {16'h0, r});
        bw(REG_INT_STAT, 32'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Result watcher and pulse counters
    always @(posedge clk_i) begin
        rd_q <= rd;
        if (rd_q) begin
            chk(rdata, exp_q.pop_front());
        end
        for (int i = 0; i < 8; i++) begin
            if (pl[i] === 1'b1) begin
                n_pulse[i]++;
            end
        end
    end

    initial begin
        #400000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk(page, 3'h0);
        bw(REG_INT_MASK, 32'h3);
        @(posedge clk_i);
        cf_set <= 8'h11;
        ce_set <= 8'h42;
        @(posedge clk_i);
        cf_set <= 8'h00;
        ce_set <= 8'h00;
        repeat (5) @(posedge clk_i);
        chk({cf, ce}, 16'h1142);
        cmd(CMD_CLR_FAULTS, 1'b1, 2'd1 - 2'd1, 16'h0, 1'b0, 16'h0);
        chk({cf, ce}, 16'h0);
        cmd(CMD_PAGE, 1'b1, 2'd1, 16'h0005, 1'b0, 16'h0);
        cmd(CMD_PAGE, 1'b1, 2'd1, 16'h0009, 1'b1, 16'h0);
        chk(page, 3'h5);
        cmd(CMD_PAGE, 1'b0, 2'd1, 16'h0, 1'b0, 16'h0005);
        // Each code but 00h in one legal form (03h and 4Fh only in refused forms), plus other refused ones; mask alternates
        foreach (tbl[i]) begin
            t = tbl[i];
            mk = i[0];
            rnd = 16'($random(seed));
            wd = 16'($random(seed));
            rd_data <= rnd;
            bw(REG_INT_MASK, {30'h0, mk, mk});
            cmd(t[19:12], t[8], t[5:4], wd, t[0],
                t[8] ? 16'h0 : (t[5:4] == 2'd1 ? {8'h0, rnd[7:0]} : rnd));
            if (t[8] && !t[0] && t[5:4] != 2'd0) begin
                chk(wdat, wd);
            end
        end
        // Frozen clock enable: the fault event and the mask write are both lost
        run <= 1'b0;
        cf_set <= 8'h01;
        bw(REG_INT_MASK, 32'h0);
        run <= 1'b1;
        cf_set <= 8'h00;
        br(REG_INT_MASK, 32'h3);
        chk(cf[0], 1'b0);
        repeat (4) @(posedge clk_i);
        chk({n_pulse[0][7:0], n_pulse[1][7:0], n_pulse[2][7:0]}, 24'h010101);
        chk({n_pulse[3][7:0], n_pulse[4][7:0], n_pulse[5][7:0]}, 24'h010107);
        chk({n_pulse[6][7:0], n_pulse[7][7:0]}, 16'h0610);
        chk(cf[7], 1'b1);
        chk(exp_q.size(), 32'd0);
        test_done();
    end
endmodule // test_pmbus_command_decoder
`default_nettype wire
